// file: rtl/ncmfe_pkg.sv
/*
 * Shared constants, types and decode helpers of the nibble core executor.
 * Assumes one system clock and an asynchronous active-low reset.
 */
package ncmfe_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses on the Avalon slave)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CMD   = 3'h0;
  localparam logic [2:0] REG_CORE  = 3'h1;
  localparam logic [2:0] REG_FLAGS = 3'h2;
  localparam logic [2:0] REG_PORT  = 3'h3;

  // ----------------------------------------------------------------
  // Widths, reset values and timing
  // ----------------------------------------------------------------
  localparam int         PC_W        = 11;
  localparam int         RAM_AW      = 7;
  localparam int         CLK_NS      = 100;
  localparam int         MC_NS       = 400;
  localparam int         MC_CLKS     = MC_NS / CLK_NS;
  localparam logic [3:0] NIB_RST     = 4'h0;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP       = 5'b00000,
    OP_MOV_WR_R  = 5'b00001,
    OP_MOV_R_WR  = 5'b00010,
    OP_MOVE_WITH_ACC_COPY_WR_R = 5'b00011,
    OP_MOVE_WITH_ACC_COPY_R_WR = 5'b00100,
    OP_MOV_R_ACC = 5'b00101,
    OP_MOV_ACC_R = 5'b00110,
    OP_MOV_R_IMM = 5'b00111,
    OP_LD_IND    = 5'b01000,
    OP_ST_IND    = 5'b01001,
    OP_LUT_LO    = 5'b01010,
    OP_LUT_HI    = 5'b01011,
    OP_TBL_R     = 5'b01100,
    OP_TBL_WR    = 5'b01101,
    OP_SER_IN    = 5'b01110,
    OP_SER_OUT   = 5'b01111,
    OP_PMF_CLR   = 5'b10000,
    OP_PMF_SET   = 5'b10001,
    OP_EVF_CLR   = 5'b10010,
    OP_PEF_WR    = 5'b10011,
    OP_IEF_WR    = 5'b10100,
    OP_HEF_WR    = 5'b10101,
    OP_SEF_WR    = 5'b10110,
    OP_PSA_RD    = 5'b10111,
    OP_PSA_CLR   = 5'b11000,
    OP_PSC_RD    = 5'b11001,
    OP_PSC_CLR   = 5'b11010,
    OP_DIV_CLR   = 5'b11011,
    OP_CALL      = 5'b11100,
    OP_RTN       = 5'b11101,
    OP_PAGE_RD   = 5'b11110,
    OP_PAGE_WR   = 5'b11111
  } ncmfe_op_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } ncmfe_state_t;

  // Command word: low 27 bits of the CMD register write.
  typedef struct packed {
    logic [6:0]  r;    // RAM location operand
    logic [3:0]  wr;   // working register index
    logic [10:0] imm;  // immediate or call target
    ncmfe_op_t   op;
  } ncmfe_cmd_t;

  // Machine cycles an instruction takes.
  function automatic logic [1:0] ncmfe_mc(input ncmfe_op_t op);
    case (op)
      OP_LD_IND, OP_ST_IND, OP_TBL_R, OP_TBL_WR, OP_SER_IN: return 2'h2;
      default: return 2'h1;
    endcase
  endfunction : ncmfe_mc

  // True for instructions that reload the zero flag.
  function automatic logic ncmfe_zf_op(input ncmfe_op_t op);
    case (op)
      OP_MOVE_WITH_ACC_COPY_WR_R, OP_MOVE_WITH_ACC_COPY_R_WR, OP_MOV_ACC_R, OP_PSA_RD, OP_PSC_RD,
      OP_PAGE_RD: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : ncmfe_zf_op

endpackage : ncmfe_pkg

// file: rtl/ncmfe_ram.sv
/*
 * Data RAM of the core, 128 nibbles, working registers at 0 to 15.
 * Read data come out of a register one clock after the address.
 */
module ncmfe_ram
  import ncmfe_pkg::*;
#(
  parameter int AW = RAM_AW
) (
  input  wire logic          clk,     // system clock
  input  wire logic          reset_n, // asynchronous reset, active low
  input  wire logic          we,      // write strobe
  input  wire logic [AW-1:0] waddr,   // write address
  input  wire logic [3:0]    wdata,   // write data
  input  wire logic [AW-1:0] raddr,   // read address
  output logic      [3:0]    rdata    // registered read data
);

  logic [3:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= NIB_RST;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : ncmfe_ram

// file: rtl/ncmfe_exec.sv
/*
 * Executor for the data-move, table, serial, flag, status, divider-clear
 * and call instructions of a 4-bit core. Software posts one instruction
 * by writing the CMD register; the write stalls until it has retired.
 * Assumes lookup ROM, serial buffer and event sources on the same clock.
 */
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
module ncmfe_exec
  import ncmfe_pkg::*;
#(
  parameter int LUT_AW      = 11,
  parameter int STACK_DEPTH = 8
) (
  input  wire logic              clk,                 // 10 MHz clock
  input  wire logic              reset_n,             // async reset
  input  wire logic [2:0]        avm_address,         // word address
  input  wire logic              avm_read,            // read request
  input  wire logic              avm_write,           // write request
  input  wire logic [31:0]       avm_writedata,       // write data
  output logic      [31:0]       avm_readdata,        // read data
  output logic                   avm_waitrequest,     // stall
  output logic      [LUT_AW-1:0] lut_addr,            // lookup address
  input  wire logic [3:0]        lut_data,            // lookup entry
  input  wire logic [3:0]        serial_in_buffer,    // received nibble
  output logic                   serial_in_clk_pin,   // receive clock
  output logic      [7:0]        serial_out_pin,      // memory, acc
  output logic                   serial_out_clk_pin,  // send clock
  output logic                   divider_a_low_clr,   // low stage reset
  input  wire logic [3:0]        event_set,           // event pulses
  input  wire logic [3:0]        port_a_set,          // status A pulses
  input  wire logic [3:0]        port_c_set,          // status C pulses
  output logic      [3:0]        parameter_flags,     // parameter bits
  output logic      [3:0]        event_flags,         // sticky events
  output logic      [3:0]        port_enable_flags,   // port enables
  output logic      [7:0]        irq_enable_flags,    // irq enables
  output logic      [7:0]        hold_release_enables,// hold wake
  output logic      [3:0]        stop_wake_enables    // port C wake
);

  localparam int CW  = $clog2(2 * MC_CLKS + 1);
  localparam int SPW = $clog2(STACK_DEPTH);

  // The status word carries a 3-bit stack pointer, hence the upper depth.
  if (LUT_AW < 11 || LUT_AW > 12 || MC_CLKS < 4 || STACK_DEPTH > 8 ||
      STACK_DEPTH < 2 || 2**SPW != STACK_DEPTH) begin : g_bad_params
    $error("ncmfe_exec: unsupported parameter values");
  end


  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  ncmfe_state_t    state;
  ncmfe_cmd_t      cmd;
  logic [CW-1:0]   cnt;
  logic [3:0]      accumulator;
  logic            zero_flag;
  logic            carry_flag;
  logic [3:0]      page;
  logic [7:0]      lut_addr_buf;
  logic [3:0]      port_status_a;
  logic [3:0]      port_status_c;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SPW-1:0]  sp;
  logic [3:0]      d1;
  logic [3:0]      d2;
  logic [3:0]      lut_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [3:0] wr_rdata;
  wire logic       exec      = (state == ST_EXEC);
  wire logic [1:0] mc        = ncmfe_mc(cmd.op);
  wire logic [CW-1:0] last   = CW'(32'(mc) * MC_CLKS - 1);
  wire logic       done      = exec && (cnt == last);
  wire logic       req_free  = avm_waitrequest && (state == ST_IDLE);
  wire logic       take_rd   = avm_read && req_free;
  wire logic       start     = avm_write && req_free &&
                               (avm_address == REG_CMD);
  wire logic       take_wr   = avm_write && req_free &&
                               (avm_address != REG_CMD);
  wire logic       wr_first  = (cmd.op == OP_MOV_R_WR) ||
                               (cmd.op == OP_MOVE_WITH_ACC_COPY_R_WR);
  wire logic [6:0] ind_addr  = {page[2:0], d1};
  wire logic [6:0] addr_a    = wr_first ? {3'h0, cmd.wr} : cmd.r;
  wire logic [6:0] addr_b    = (cmd.op == OP_LD_IND) ? ind_addr
                                                     : {3'h0, cmd.wr};
  wire logic [6:0] ram_raddr = (cnt == '0) ? addr_a : addr_b;
  wire logic [11:0] tab_idx  = {lut_addr_buf, accumulator};
  wire logic [11:0] imm_idx  = {1'b0, cmd.imm[6:0], accumulator};
  wire logic [SPW-1:0] sp_dec = sp - SPW'(1);

  // RAM write target and data for the retiring instruction.
  logic       ram_we;
  logic [6:0] ram_waddr;
  logic [3:0] ram_wdata;
  logic       acc_ld;
  always_comb begin
    ram_we    = 1'b0;
    ram_waddr = cmd.r;
    ram_wdata = d1;
    acc_ld    = 1'b0;
    unique case (cmd.op)
      OP_MOV_WR_R: begin
        ram_we = 1'b1; ram_waddr = {3'h0, cmd.wr};
      end
      OP_MOVE_WITH_ACC_COPY_WR_R: begin
        ram_we = 1'b1; ram_waddr = {3'h0, cmd.wr}; acc_ld = 1'b1;
      end
      OP_MOV_R_WR:  ram_we = 1'b1;
      OP_MOVE_WITH_ACC_COPY_R_WR: begin
        ram_we = 1'b1; acc_ld = 1'b1;
      end
      OP_MOV_R_ACC: begin
        ram_we = 1'b1; ram_wdata = accumulator;
      end
      OP_MOV_ACC_R: acc_ld = 1'b1;
      OP_MOV_R_IMM: begin
        ram_we = 1'b1; ram_wdata = cmd.imm[3:0];
      end
      OP_LD_IND: begin
        ram_we = 1'b1; ram_waddr = {3'h0, cmd.wr}; ram_wdata = d2;
      end
      OP_ST_IND: begin
        ram_we = 1'b1; ram_waddr = ind_addr; ram_wdata = d2;
      end
      OP_TBL_R: begin
        ram_we = 1'b1; ram_wdata = lut_q;
      end
      OP_TBL_WR: begin
        ram_we = 1'b1; ram_waddr = {3'h0, cmd.wr}; ram_wdata = lut_q;
      end
      OP_SER_IN: begin
        ram_we = 1'b1; ram_wdata = serial_in_buffer; acc_ld = 1'b1;
      end
      OP_PSA_RD: begin
        ram_we = 1'b1; ram_wdata = port_status_a; acc_ld = 1'b1;
      end
      OP_PSC_RD: begin
        ram_we = 1'b1; ram_wdata = port_status_c; acc_ld = 1'b1;
      end
      OP_PAGE_RD: begin
        ram_we = 1'b1; ram_wdata = page; acc_ld = 1'b1;
      end
      default: ram_we = 1'b0;
    endcase
    ram_we = ram_we && done;
  end

  ncmfe_ram #(.AW(RAM_AW)) u_ram (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (ram_we),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata),
    .raddr   (ram_raddr),
    .rdata   (wr_rdata)
  );

  // ----------------------------------------------------------------
  // Sequencer and operand capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cmd   <= '0;
      cnt   <= '0;
      d1    <= NIB_RST;
      d2    <= NIB_RST;
      lut_q <= NIB_RST;
    end else begin
      if (start) begin
        state <= ST_EXEC;
        cmd   <= ncmfe_cmd_t'(avm_writedata[26:0]);
        cnt   <= '0;
      end else if (done) begin
        state <= ST_IDLE;
      end else if (exec) begin
        cnt <= cnt + CW'(1);
      end
      if (exec && cnt == CW'(1)) d1 <= wr_rdata;
      if (exec && cnt == CW'(3)) d2 <= wr_rdata;
      if (exec && cnt == CW'(2)) lut_q <= lut_data;
    end
  end

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  // Hardware set pulses win over a clear in the same cycle, so no
  // event arriving in the clock in which the clear takes effect is lost.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accumulator          <= NIB_RST;
      zero_flag            <= 1'b0;
      carry_flag           <= 1'b0;
      page                 <= NIB_RST;
      lut_addr_buf         <= BYTE_RST;
      parameter_flags      <= NIB_RST;
      port_enable_flags    <= NIB_RST;
      irq_enable_flags     <= BYTE_RST;
      hold_release_enables <= BYTE_RST;
      stop_wake_enables    <= NIB_RST;
    end else if (done) begin
      if (acc_ld) begin
        accumulator <= ram_wdata;
        if (ncmfe_zf_op(cmd.op)) zero_flag <= (ram_wdata == 4'h0);
      end
      unique case (cmd.op)
        OP_PAGE_WR: page <= d1;
        OP_LUT_LO:  lut_addr_buf[3:0] <= d1;
        OP_LUT_HI:  lut_addr_buf[7:4] <= d1;
        OP_PMF_CLR: parameter_flags <= parameter_flags & ~cmd.imm[3:0];
        OP_PMF_SET: parameter_flags <= parameter_flags | cmd.imm[3:0];
        OP_PEF_WR:  port_enable_flags <= cmd.imm[3:0];
        OP_IEF_WR:  irq_enable_flags <= cmd.imm[7:0];
        OP_HEF_WR:  hold_release_enables <= cmd.imm[7:0];
        OP_SEF_WR:  stop_wake_enables <= cmd.imm[3:0];
        default:    carry_flag <= carry_flag;
      endcase
    end
  end

  wire logic evf_clr = done && (cmd.op == OP_EVF_CLR);
  wire logic psa_clr = done && (cmd.op == OP_PSA_CLR);
  wire logic psc_clr = done && (cmd.op == OP_PSC_CLR);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_flags   <= NIB_RST;
      port_status_a <= NIB_RST;
      port_status_c <= NIB_RST;
    end else begin
      event_flags   <= (evf_clr ? event_flags & ~cmd.imm[3:0]
                                : event_flags) | event_set;
      port_status_a <= (psa_clr ? 4'h0 : port_status_a) | port_a_set;
      port_status_c <= (psc_clr ? 4'h0 : port_status_c) | port_c_set;
    end
  end

  // Stack wraps silently past its depth, as a small core's does.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= PC_RST;
      sp <= '0;
    end else if (done) begin
      unique case (cmd.op)
        OP_CALL: begin
          stack_mem[sp] <= pc + PC_W'(1);
          sp            <= sp + SPW'(1);
          pc            <= cmd.imm;
        end
        OP_RTN: begin
          sp <= sp_dec;
          pc <= stack_mem[sp_dec];
        end
        default: pc <= pc + PC_W'(1);
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pins toward ROM, serial port and divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lut_addr           <= '0;
      serial_in_clk_pin  <= 1'b0;
      serial_out_pin     <= BYTE_RST;
      serial_out_clk_pin <= 1'b0;
      divider_a_low_clr  <= 1'b0;
    end else begin
      if (exec && cnt == '0) begin
        lut_addr <= (cmd.op == OP_TBL_WR) ? imm_idx[LUT_AW-1:0]
                                          : tab_idx[LUT_AW-1:0];
      end
      serial_in_clk_pin  <= done && (cmd.op == OP_SER_IN);
      serial_out_clk_pin <= done && (cmd.op == OP_SER_OUT);
      if (done && cmd.op == OP_SER_OUT) serial_out_pin <= {d1, accumulator};
      divider_a_low_clr  <= done && (cmd.op == OP_DIV_CLR);
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------
  wire logic [31:0] rd_mux =
    (avm_address == REG_CMD)   ? {5'h0, cmd} :
    (avm_address == REG_CORE)  ? {3'h0, pc, 3'(sp), 3'h0, page, 2'h0,
                                  carry_flag, zero_flag,
                                  accumulator} :
    (avm_address == REG_FLAGS) ? {hold_release_enables, irq_enable_flags,
                                  stop_wake_enables, port_enable_flags,
                                  event_flags, parameter_flags} :
    (avm_address == REG_PORT)  ? {16'h0, lut_addr_buf, port_status_c,
                                  port_status_a} : 32'h0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avm_waitrequest <= 1'b1;
      avm_readdata    <= 32'h0;
    end else begin
      avm_waitrequest <= !(take_rd || take_wr || done);
      if (take_rd) avm_readdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [CW:0] busy_clks;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) busy_clks <= '0;
    else if (start) busy_clks <= '0;
    else if (exec) busy_clks <= busy_clks + (CW+1)'(1);
  end

  AST_IND_LOAD_LEN: assert property ($fell(avm_waitrequest) &&
    cmd.op == OP_LD_IND |-> busy_clks == (CW+1)'(2 * MC_CLKS))
    else $error("indirect load did not take two machine cycles");
  AST_IND_STORE_ADDR: assert property (ram_we &&
    cmd.op == OP_ST_IND |-> ram_waddr == {page[2:0], d1})
    else $error("indirect store went to the wrong address");
  AST_TABLE_ADDR: assert property (exec && cnt == CW'(1) &&
    cmd.op == OP_TBL_R |-> lut_addr == tab_idx[LUT_AW-1:0])
    else $error("table read address wrong");
  AST_IMM_TABLE_ADDR: assert property (exec && cnt == CW'(1) &&
    cmd.op == OP_TBL_WR |-> lut_addr == imm_idx[LUT_AW-1:0])
    else $error("immediate table address wrong");
  AST_SERIAL_IN: assert property (serial_in_clk_pin |->
    accumulator == $past(serial_in_buffer) ##1 !serial_in_clk_pin)
    else $error("serial input not loaded with its clock pulse");
  AST_PMF_SET: assert property (done && cmd.op == OP_PMF_SET |=>
    parameter_flags == ($past(parameter_flags) | $past(cmd.imm[3:0])))
    else $error("parameter flag set touched other bits");
  AST_EVF_CLEAR: assert property (evf_clr |=> event_flags ==
    (($past(event_flags) & ~$past(cmd.imm[3:0])) | $past(event_set)))
    else $error("event flag clear wrong or lost an event");
  AST_SEF_PORT_C: assert property (done && cmd.op == OP_SEF_WR |=>
    stop_wake_enables == $past(cmd.imm[3:0]))
    else $error("wake enables not taken from immediate");
  AST_PSA_READ: assert property (done && cmd.op == OP_PSA_RD |=>
    accumulator == $past(port_status_a) && zero_flag == (accumulator == 4'h0))
    else $error("port status A read wrong");
  AST_PS_CLEAR: assert property (psa_clr |=>
    port_status_a == $past(port_a_set) && $stable(carry_flag))
    else $error("port status A clear wrong");
  AST_DIV_PULSE: assert property ($rose(divider_a_low_clr) |->
    $past(cmd.op) == OP_DIV_CLR ##1 !divider_a_low_clr)
    else $error("divider clear pulse wrong");
  AST_CALL: assert property (done && cmd.op == OP_CALL |=>
    pc == $past(cmd.imm) && stack_mem[sp_dec] == $past(pc) + PC_W'(1))
    else $error("call did not push and jump");
  AST_FLAGS_KEPT: assert property (done && !ncmfe_zf_op(cmd.op) |=>
    $stable(zero_flag) && $stable(carry_flag))
    else $error("flags changed by an instruction that keeps them");

  COV_IND_LOAD: cover property (done && cmd.op == OP_LD_IND);
  COV_CALL_RTN: cover property (done && cmd.op == OP_CALL ##[1:40]
    done && cmd.op == OP_RTN);
  COV_EVF_RACE: cover property (evf_clr && |(event_set & cmd.imm[3:0]));

endmodule : ncmfe_exec

// file: dv/ncmfe_rom_model.sv
/* Lookup ROM model on the table port of the executor.
   Assumes one clock; the entry follows the address one clock late. */
module ncmfe_rom_model
  import ncmfe_pkg::*;
#(
  parameter int AW = 11
) (
  input  wire logic          clk,      // system clock
  input  wire logic [AW-1:0] lut_addr, // lookup address
  output logic      [3:0]    lut_data  // entry, one clock late
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Contents
  // ----------
  // Every address bit feeds the entry, so a wrong index shows.
  always_ff @(posedge clk) begin
    lut_data <= lut_addr[3:0] ^ lut_addr[7:4] ^ {1'b0, lut_addr[10:8]};
  end
endmodule : ncmfe_rom_model

// file: dv/ncmfe_exec_tb_top.sv
/* Self-checking bench of the executor, one task per scenario.
   Assumes the lookup ROM model on the table port. */
module ncmfe_exec_tb_top
  import ncmfe_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset_n, avm_read, avm_write, avm_waitrequest;
  logic        serial_in_clk_pin, serial_out_clk_pin, divider_a_low_clr;
  logic [2:0]  avm_address;
  logic [31:0] avm_writedata, avm_readdata, q;
  logic [10:0] lut_addr, pc0;
  logic [3:0]  lut_data, serial_in_buffer, event_set, port_a_set, port_c_set;
  logic [3:0]  parameter_flags, event_flags, port_enable_flags;
  logic [3:0]  stop_wake_enables;
  logic [7:0]  serial_out_pin, irq_enable_flags, hold_release_enables;
  logic [11:0] pulses = 12'h000;
  int          n_errors = 0, checks_done = 0, cyc = 0;

  always #50 clk = ~clk;

  ncmfe_exec dut_u (
    .clk, .reset_n, .avm_address, .avm_read, .avm_write, .avm_writedata,
    .avm_readdata, .avm_waitrequest, .lut_addr, .lut_data,
    .serial_in_buffer, .serial_in_clk_pin, .serial_out_pin,
    .serial_out_clk_pin, .divider_a_low_clr, .event_set, .port_a_set,
    .port_c_set, .parameter_flags, .event_flags, .port_enable_flags,
    .irq_enable_flags, .hold_release_enables, .stop_wake_enables
  );
  ncmfe_rom_model rom_u (.clk, .lut_addr, .lut_data);

  // ----------
  // Helpers
  // ----------
  // Each pulse output counts in its own nibble; a stuck pulse overcounts.
  always @(posedge clk) begin
    if (reset_n) begin
      pulses <= pulses + {3'h0, divider_a_low_clr, 3'h0, serial_out_clk_pin,
                          3'h0, serial_in_clk_pin};
    end
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [31:0] d, output int n);
    n = 0;
    avm_address <= a;
    avm_writedata <= d;
    avm_write <= w;
    avm_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avm_waitrequest !== 1'b0);
    q = avm_readdata;
    avm_write <= 1'b0;
    avm_read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd(input logic [2:0] a);
    int n;
    bus(1'b0, a, 32'h0000_0000, n);
  endtask : rd

  // The write stalls until retire, so its length gives the cycle count.
  task automatic ex(input ncmfe_op_t op, input logic [10:0] imm,
                    input logic [3:0] wr, input logic [6:0] r, input int mc);
    int n;
    bus(1'b1, REG_CMD, {5'h00, r, wr, imm, op}, n);
    chk(32'(n), 32'(4 * mc + 2));
  endtask : ex

  task automatic ck_ram(input logic [6:0] r, input logic [3:0] e);
    ex(OP_MOV_ACC_R, 11'h000, 4'h0, r, 1);
    rd(REG_CORE);
    chk(q[4:0], {e == 4'h0, e});
  endtask : ck_ram

  // ----------
  // Scenarios
  // ----------
  task automatic t_move;
    ex(OP_MOV_R_IMM, 11'h009, 4'h0, 7'h01, 1);
    ex(OP_MOV_R_IMM, 11'h003, 4'h0, 7'h05, 1);
    ex(OP_MOV_R_IMM, 11'h00A, 4'h0, 7'h06, 1);
    ex(OP_PAGE_WR, 11'h000, 4'h0, 7'h06, 1);
    ex(OP_MOV_R_IMM, 11'h000, 4'h0, 7'h07, 1);
    ck_ram(7'h07, 4'h0);
    ex(OP_ST_IND, 11'h000, 4'h1, 7'h05, 2);
    rd(REG_CORE);
    chk(q[5:0], 6'h10);
    ck_ram(7'h23, 4'h9);
    ex(OP_LD_IND, 11'h000, 4'h2, 7'h05, 2);
    ck_ram(7'h02, 4'h9);
  endtask : t_move

  task automatic t_table;
    ex(OP_MOV_R_IMM, 11'h005, 4'h0, 7'h08, 1);
    ex(OP_LUT_LO, 11'h000, 4'h0, 7'h08, 1);
    ex(OP_MOV_R_IMM, 11'h00A, 4'h0, 7'h08, 1);
    ex(OP_LUT_HI, 11'h000, 4'h0, 7'h08, 1);
    rd(REG_PORT);
    chk(q[15:8], 8'hA5);
    ex(OP_MOV_R_IMM, 11'h00C, 4'h0, 7'h08, 1);
    ck_ram(7'h08, 4'hC);
    ex(OP_TBL_R, 11'h000, 4'h0, 7'h09, 2);
    ex(OP_TBL_WR, 11'h052, 4'h3, 7'h00, 2);
    chk(lut_addr, 11'h52C);
    ck_ram(7'h09, 4'hB);
    ck_ram(7'h03, 4'hB);
  endtask : t_table

  task automatic t_serial;
    serial_in_buffer <= 4'h6;
    ex(OP_SER_IN, 11'h000, 4'h0, 7'h0A, 2);
    rd(REG_CORE);
    chk(q[3:0], 4'h6);
    ck_ram(7'h05, 4'h3);
    ex(OP_SER_OUT, 11'h000, 4'h0, 7'h0A, 1);
    chk(serial_out_pin, 8'h63);
  endtask : t_serial

  task automatic t_flags;
    ex(OP_PMF_SET, 11'h00A, 4'h0, 7'h00, 1);
    ex(OP_PMF_CLR, 11'h003, 4'h0, 7'h00, 1);
    chk(parameter_flags, 4'h8);
    event_set <= 4'h7;
    @(posedge clk);
    event_set <= 4'h0;
    ex(OP_EVF_CLR, 11'h005, 4'h0, 7'h00, 1);
    chk(event_flags, 4'h2);
    ex(OP_PEF_WR, 11'h009, 4'h0, 7'h00, 1);
    ex(OP_PEF_WR, 11'h006, 4'h0, 7'h00, 1);
    ex(OP_IEF_WR, 11'h0A5, 4'h0, 7'h00, 1);
    ex(OP_HEF_WR, 11'h03C, 4'h0, 7'h00, 1);
    ex(OP_SEF_WR, 11'h0F9, 4'h0, 7'h00, 1);
    rd(REG_FLAGS);
    chk(q, 32'h3CA5_9628);
    chk({hold_release_enables, irq_enable_flags, stop_wake_enables,
         port_enable_flags}, 24'h3CA596);
  endtask : t_flags

  task automatic t_status;
    port_a_set <= 4'h3;
    port_c_set <= 4'hC;
    @(posedge clk);
    port_a_set <= 4'h0;
    port_c_set <= 4'h0;
    ex(OP_PSA_RD, 11'h000, 4'h0, 7'h0B, 1);
    rd(REG_CORE);
    chk(q[4:0], 5'h03);
    ck_ram(7'h0B, 4'h3);
    ex(OP_PSC_RD, 11'h000, 4'h0, 7'h0C, 1);
    rd(REG_CORE);
    chk(q[4:0], 5'h0C);
    ex(OP_PSC_CLR, 11'h000, 4'h0, 7'h00, 1);
    ex(OP_PSA_CLR, 11'h000, 4'h0, 7'h00, 1);
    rd(REG_CORE);
    chk(q[5:0], 6'h0C);
    rd(REG_PORT);
    chk(q[7:0], 8'h00);
    ex(OP_PAGE_RD, 11'h000, 4'h0, 7'h0D, 1);
    rd(REG_CORE);
    chk(q[11:0], 12'hA0A);
    ck_ram(7'h0D, 4'hA);
  endtask : t_status

  task automatic t_call;
    rd(REG_CORE);
    pc0 = q[28:18];
    ex(OP_CALL, 11'h5A3, 4'h0, 7'h00, 1);
    rd(REG_CORE);
    chk(q[28:15], {11'h5A3, 3'h1});
    ex(OP_RTN, 11'h000, 4'h0, 7'h00, 1);
    rd(REG_CORE);
    chk(q[28:15], {pc0 + 11'h001, 3'h0});
    ex(OP_DIV_CLR, 11'h000, 4'h0, 7'h00, 1);
    rd(3'h5);
    chk(q, 32'h0000_0000);
    chk(pulses, 12'h111);
  endtask : t_call

  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  initial begin
    reset_n = 1'b0;
    avm_address = 3'h0;
    avm_read = 1'b0;
    avm_write = 1'b0;
    avm_writedata = 32'h0000_0000;
    serial_in_buffer = 4'h0;
    event_set = 4'h0;
    port_a_set = 4'h0;
    port_c_set = 4'h0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_move();
    t_table();
    t_serial();
    t_flags();
    t_status();
    t_call();
    stop_test();
  end
endmodule : ncmfe_exec_tb_top
